// *** rtl/p3s_pkg.sv ***
// Purpose: constants, register map and field layout of the port 3
//          special-function block
// Assumes: 32-bit APB data, each register one aligned word
// Notes:   offsets are byte addresses
// *****************************************************************
// Behaviour
// - four fixed inputs, four fixed outputs
// - mode bit D1 enables analog comparators
// - config D0 routes comparators to bits 4,7
// - bits 0 and 3 interrupt on falling edge
// - bits 1,2 select falling, rising or both
// - timer 1 input bit 1, output bit 6
// - fixed interrupt mapping; mode bit D10 moves handshake 1 between bits 1/4 and 3/6
// - bits 1,2 plus inputs, bit 3 reference
// - keepers on port 0, 2, bit 0 only
// - data select low for external data access
// - data space from 4096 up, or full 64K
// - independent low-emission and open-drain selects
// - low-emission undivided clock limited to 4 MHz
// - config register at bank F location 00
// *****************************************************************
package p3s_pkg;
    // *************************************************************
    // register offsets
    // *************************************************************
    localparam int ADDR_W = 8;
    localparam logic [3:0] PCFG_BANK = 4'hF;
    localparam logic [7:0] REG_PCFG = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_RCV = 8'h08;
    localparam logic [7:0] REG_DOUT = 8'h0C;
    localparam logic [7:0] REG_PIN = 8'h10;
    localparam logic [7:0] REG_IST = 8'h14;
    localparam logic [7:0] REG_IMSK = 8'h18;
    localparam logic [7:0] REG_DSP = 8'h1C;
    // *************************************************************
    // port config fields
    // *************************************************************
    localparam int PC_CMP_OUT = 0;
    localparam int PC_OD_P1 = 1;
    localparam int PC_OD_P0 = 2;
    localparam int PC_EMI_P3 = 3;
    localparam int PC_EMI_P2 = 4;
    localparam int PC_EMI_P0 = 5;
    localparam int PC_EMI_P1 = 6;
    localparam int PC_EMI_OSC = 7;
    localparam logic [7:0] PCFG_RST = 8'h00;
    // *************************************************************
    // port 3 mode fields
    // *************************************************************
    localparam int MODE_W = 11;
    localparam int M_ANALOG = 1;
    localparam int M_EDGE1 = 2;
    localparam int M_EDGE2 = 4;
    localparam int M_DSEL_EN = 6;
    localparam int M_TOUT_EN = 7;
    localparam int M_HS0_EN = 8;
    localparam int M_HS1_EN = 9;
    localparam int M_HS1_SEL = 10;
    localparam logic [10:0] MODE_RST = 11'h000;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    // *************************************************************
    // stop-mode recovery, clocking, data space
    // *************************************************************
    localparam int S_UNDIV = 1;
    localparam logic [7:0] RCV_RST = 8'h00;
    localparam int LOW_EMI_MAX_MHZ = 4;
    localparam logic [15:0] EXT_DATA_BASE = 16'h1000;
    localparam logic [3:0] DOUT_RST = 4'h0;
    // *************************************************************
    // interrupt request index of each input bit
    // *************************************************************
    localparam int IRQ_OF_B0 = 3;
    localparam int IRQ_OF_B1 = 2;
    localparam int IRQ_OF_B2 = 0;
    localparam int IRQ_OF_B3 = 1;
endpackage

// *** rtl/p3s_sig_if.sv ***
// Purpose: carries raw inputs to the synchroniser and edges back
// Assumes: one clock domain on the far side
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface p3s_sig_if #(parameter int N = 6) ();
    logic [N-1:0] raw;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src (output raw, input lvl, input rise, input fall);
    modport det (input raw, output lvl, output rise, output fall);
endinterface
`default_nettype wire

// *** rtl/p3s_sync.sv ***
// Purpose: two-flop synchroniser plus edge detection per input
// Assumes: raw inputs asynchronous to clk
// Notes:   edges are one-cycle levels from flop outputs
`timescale 1ns/1ps
`default_nettype none
module p3s_sync #(
    parameter int N = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    p3s_sig_if.det sig
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;

    // synchroniser, then previous sample for edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (ce) begin
            meta_q <= sig.raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // compare with previous sample
    assign sig.lvl = sync_q;
    assign sig.rise = sync_q & ~prev_q;
    assign sig.fall = ~sync_q & prev_q;
endmodule // p3s_sync
`default_nettype wire

// *** rtl/p3s_top.sv ***
// Purpose: port 3 special-function logic with APB registers
// Assumes: core-side inputs are on clk; pins and comparators are not
// Notes:   zero-wait APB, answer in the access cycle
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module p3s_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] port3_in,
    input wire logic cmp1_raw,
    input wire logic cmp2_raw,
    output logic [3:0] port3_out,
    input wire logic timer1_out,
    output logic timer1_in,
    input wire logic hs0_out,
    input wire logic hs1_out,
    output logic hs0_in,
    output logic hs1_in,
    input wire logic load_external_data_op,
    input wire logic load_program_const_op,
    input wire logic [15:0] mem_addr,
    input wire logic romless_strap,
    output logic data_space_ok,
    output logic [3:0] irq_req,
    output logic irq,
    output logic analog_en,
    output logic [4:0] low_emi,
    output logic [1:0] open_drain,
    output logic keeper_en,
    output logic clk_limit_4mhz
);
    // *************************************************************
    // edge select decode, used for bits 1 and 2
    // *************************************************************
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r,
                                      input logic f);
        logic hit;
        hit = 1'b0;
        if (sel == p3s_pkg::EDGE_FALL) begin
            hit = f;
        end else if (sel == p3s_pkg::EDGE_RISE) begin
            hit = r;
        end else begin
            hit = r | f;
        end
        return hit;
    endfunction

    // *************************************************************
    // registers
    // *************************************************************
    logic [7:0] pcfg_q;
    logic [p3s_pkg::MODE_W-1:0] mode_q;
    logic [7:0] rcv_q;
    logic [3:0] dout_q;
    logic [3:0] ist_q;
    logic [3:0] ist_d;
    logic [3:0] imsk_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [3:0] out_q;
    logic [3:0] irq_req_q;
    logic irq_q;
    logic timer1_in_q;
    logic hs0_in_q;
    logic hs1_in_q;
    logic romless_q;
    logic strap_done_q;
    logic dsp_ok_q;
    logic analog_q;
    logic [4:0] emi_q;
    logic [1:0] od_q;
    logic keeper_q;
    logic clk_lim_q;

    // *************************************************************
    // input synchroniser and edge detector
    // *************************************************************
    p3s_sig_if #(.N(6)) sig_if ();

    assign sig_if.raw = {cmp2_raw, cmp1_raw, port3_in};

    p3s_sync #(.N(6)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .sig(sig_if.det)
    );

    // *************************************************************
    // apb decode
    // *************************************************************
    wire setup_ph = psel & ~penable;
    wire access_done = psel & penable & pready_q;
    wire wr_done = access_done & pwrite;
    wire rd_done = access_done & ~pwrite;
    wire hit_pcfg = (paddr == p3s_pkg::REG_PCFG);
    wire hit_mode = (paddr == p3s_pkg::REG_MODE);
    wire hit_rcv = (paddr == p3s_pkg::REG_RCV);
    wire hit_dout = (paddr == p3s_pkg::REG_DOUT);
    wire hit_pin = (paddr == p3s_pkg::REG_PIN);
    wire hit_ist = (paddr == p3s_pkg::REG_IST);
    wire hit_imsk = (paddr == p3s_pkg::REG_IMSK);
    wire hit_dsp = (paddr == p3s_pkg::REG_DSP);
    wire hit_any = hit_pcfg | hit_mode | hit_rcv | hit_dout | hit_pin
                   | hit_ist | hit_imsk | hit_dsp;
    wire ro_hit = hit_pin | hit_ist | hit_dsp;
    wire bad_acc = ~hit_any | (pwrite & ro_hit);

    // read multiplexer, unmapped reads as zero
    wire [31:0] rd_mux =
        hit_pcfg ? {24'h000000, pcfg_q} :
        hit_mode ? {21'h000000, mode_q} :
        hit_rcv ? {24'h000000, rcv_q} :
        hit_dout ? {28'h0000000, dout_q} :
        hit_pin ? {26'h0000000, sig_if.lvl} :
        hit_ist ? {28'h0000000, ist_q} :
        hit_imsk ? {28'h0000000, imsk_q} :
        hit_dsp ? {30'h00000000, romless_q, dsp_ok_q} :
        32'h00000000;

    // answer registered in setup, presented in access
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph & bad_acc;
            prdata_q <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // *************************************************************
    // writable registers
    // *************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pcfg_q <= p3s_pkg::PCFG_RST;
            mode_q <= p3s_pkg::MODE_RST;
            rcv_q <= p3s_pkg::RCV_RST;
            dout_q <= p3s_pkg::DOUT_RST;
            imsk_q <= 4'h0;
        end else if (ce && wr_done) begin
            if (hit_pcfg) begin
                pcfg_q <= pwdata[7:0];
            end else if (hit_mode) begin
                mode_q <= pwdata[p3s_pkg::MODE_W-1:0];
            end else if (hit_rcv) begin
                rcv_q <= pwdata[7:0];
            end else if (hit_dout) begin
                dout_q <= pwdata[3:0];
            end else if (hit_imsk) begin
                imsk_q <= pwdata[3:0];
            end
        end
    end

    // *************************************************************
    // mode field decode
    // *************************************************************
    wire an_on = mode_q[p3s_pkg::M_ANALOG];
    wire [1:0] sel1 = mode_q[p3s_pkg::M_EDGE1 +: 2];
    wire [1:0] sel2 = mode_q[p3s_pkg::M_EDGE2 +: 2];
    wire dsel_en = mode_q[p3s_pkg::M_DSEL_EN];
    wire tout_en = mode_q[p3s_pkg::M_TOUT_EN];
    wire hs0_en = mode_q[p3s_pkg::M_HS0_EN];
    wire hs1_en = mode_q[p3s_pkg::M_HS1_EN];
    wire hs1_sel = mode_q[p3s_pkg::M_HS1_SEL];
    wire cmp_out = pcfg_q[p3s_pkg::PC_CMP_OUT];

    // *************************************************************
    // interrupt sources
    // *************************************************************
    // analog mode: bits 1,2 follow comparators against bit 3
    wire src1_r = an_on ? sig_if.rise[4] : sig_if.rise[1];
    wire src1_f = an_on ? sig_if.fall[4] : sig_if.fall[1];
    wire src2_r = an_on ? sig_if.rise[5] : sig_if.rise[2];
    wire src2_f = an_on ? sig_if.fall[5] : sig_if.fall[2];
    wire ev0 = sig_if.fall[0];
    wire ev3 = sig_if.fall[3];
    wire ev1 = edge_hit(sel1, src1_r, src1_f);
    wire ev2 = edge_hit(sel2, src2_r, src2_f);

    // request vector by index
    logic [3:0] req;
    always_comb begin
        req = 4'h0;
        req[p3s_pkg::IRQ_OF_B0] = ev0;
        req[p3s_pkg::IRQ_OF_B1] = ev1;
        req[p3s_pkg::IRQ_OF_B2] = ev2;
        req[p3s_pkg::IRQ_OF_B3] = ev3;
    end

    // sticky status, read clears only bits it returned, a new event wins
    assign ist_d = (ist_q & ~(prdata_q[3:0] & {4{rd_done & hit_ist}})) | req;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ist_q <= 4'h0;
            irq_req_q <= 4'h0;
            irq_q <= 1'b0;
        end else if (ce) begin
            ist_q <= ist_d;
            irq_req_q <= req;
            irq_q <= |(ist_d & imsk_q);
        end
    end

    // *************************************************************
    // output pins
    // *************************************************************
    // data select: low for external data, high otherwise
    wire dsel_lvl = ~load_external_data_op | load_program_const_op;
    wire hs1_b4 = hs1_en & ~hs1_sel;
    wire hs1_b6 = hs1_en & hs1_sel;

    // bit 4: comparator 1, data select, handshake, data
    wire out4 = (an_on & cmp_out) ? sig_if.lvl[4] :
                dsel_en ? dsel_lvl :
                hs1_b4 ? hs1_out : dout_q[0];
    wire out5 = hs0_en ? hs0_out : dout_q[1];
    wire out6 = tout_en ? timer1_out :
                hs1_b6 ? hs1_out : dout_q[2];
    wire out7 = (an_on & cmp_out) ? sig_if.lvl[5] : dout_q[3];

    // data space check on each external data access
    wire dsp_in = romless_q |
                  (mem_addr >= p3s_pkg::EXT_DATA_BASE);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= 4'hF;
            timer1_in_q <= 1'b0;
            hs0_in_q <= 1'b0;
            hs1_in_q <= 1'b0;
        end else if (ce) begin
            out_q <= {out7, out6, out5, out4};
            timer1_in_q <= sig_if.lvl[1];
            hs0_in_q <= sig_if.lvl[2];
            hs1_in_q <= hs1_sel ? sig_if.lvl[3] : sig_if.lvl[1];
        end
    end

    // strap caught on first enabled edge after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            romless_q <= 1'b0;
            strap_done_q <= 1'b0;
            dsp_ok_q <= 1'b0;
        end else if (ce) begin
            if (!strap_done_q) begin
                romless_q <= romless_strap;
                strap_done_q <= 1'b1;
            end
            if (load_external_data_op) begin
                dsp_ok_q <= dsp_in;
            end
        end
    end

    // *************************************************************
    // pad configuration
    // *************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            analog_q <= 1'b0;
            emi_q <= 5'h00;
            od_q <= 2'h0;
            keeper_q <= 1'b0;
            clk_lim_q <= 1'b0;
        end else if (ce) begin
            analog_q <= an_on;
            emi_q <= {pcfg_q[p3s_pkg::PC_EMI_OSC],
                      pcfg_q[p3s_pkg::PC_EMI_P3],
                      pcfg_q[p3s_pkg::PC_EMI_P2],
                      pcfg_q[p3s_pkg::PC_EMI_P1],
                      pcfg_q[p3s_pkg::PC_EMI_P0]};
            od_q <= {pcfg_q[p3s_pkg::PC_OD_P1],
                     pcfg_q[p3s_pkg::PC_OD_P0]};
            keeper_q <= 1'b1;
            clk_lim_q <= pcfg_q[p3s_pkg::PC_EMI_OSC]
                         & rcv_q[p3s_pkg::S_UNDIV];
        end
    end

    // *************************************************************
    // output assignments
    // *************************************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign port3_out = out_q;
    assign timer1_in = timer1_in_q;
    assign hs0_in = hs0_in_q;
    assign hs1_in = hs1_in_q;
    assign data_space_ok = dsp_ok_q;
    assign irq_req = irq_req_q;
    assign irq = irq_q;
    assign analog_en = analog_q;
    assign low_emi = emi_q;
    assign open_drain = od_q;
    assign keeper_en = keeper_q;
    assign clk_limit_4mhz = clk_lim_q;
endmodule // p3s_top
`default_nettype wire

// *** tb/p3s_checker.sv ***
// Purpose: port-level assertions for the port 3 special-function block
// Assumes: one clock domain; ce held high by the bench
// Notes: bound to p3s_top after the module
`timescale 1ns/1ps
`default_nettype none
module p3s_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] port3_in,
    input wire logic [3:0] irq_req,
    input wire logic load_external_data_op,
    input wire logic [15:0] mem_addr,
    input wire logic romless_strap,
    input wire logic data_space_ok,
    input wire logic keeper_en,
    input wire logic clk_limit_4mhz,
    input wire logic [4:0] low_emi,
    input wire logic timer1_in
);
    // *****************************************************************
    // bus, pin and configuration relations
    // *****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ans_in_time_a: assert property (
        psel && !penable && ce |=> pready) else $error("no answer after setup");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("ready held two cycles");
    err_with_ready_a: assert property (
        pslverr |-> pready) else $error("error flag without ready");
    fall_irq_a: assert property (
        $fell(port3_in[0]) |-> ##[1:5] irq_req[3]) else $error("bit0 fall lost");
    rise_quiet_a: assert property (
        $rose(port3_in[3]) |-> ##1 !irq_req[1] [*5]) else $error("bit3 rise raised request");
    space_ok_a: assert property (
        load_external_data_op |=> data_space_ok ==
        (romless_strap || $past(mem_addr) >= p3s_pkg::EXT_DATA_BASE))
        else $error("data space flag wrong");
    keeper_on_a: assert property (
        $past(rst_b) |-> keeper_en) else $error("keeper off after reset");
    clk_limit_a: assert property (
        clk_limit_4mhz |-> low_emi[4]) else $error("clock limit without slow oscillator");
    timer_in_a: assert property (
        $rose(port3_in[1]) |-> ##[1:5] timer1_in) else $error("timer input not following");
endmodule // p3s_checker
bind p3s_top p3s_checker i_chk (.clk, .rst_b, .ce, .psel, .penable, .pready, .pslverr,
    .port3_in, .irq_req, .load_external_data_op, .mem_addr, .romless_strap,
    .data_space_ok, .keeper_en, .clk_limit_4mhz, .low_emi, .timer1_in);
`default_nettype wire

// *** tb/p3s_pins_model.sv ***
// Purpose: pins, comparator front ends and memory strobes outside the port
// Assumes: driven from the bench by task calls
// Notes: voltages are plain millivolt integers
`timescale 1ns/1ps
`default_nettype none
module p3s_pins_model (
    input wire logic clk,
    output logic [3:0] port3_in,
    output logic cmp1_raw,
    output logic cmp2_raw,
    output logic load_external_data_op,
    output logic load_program_const_op,
    output logic [15:0] mem_addr
);
    // *****************************************************************
    // analog and digital pin drive
    // *****************************************************************
    int vin1 = 0;
    int vin2 = 0;
    int vref = 0;
    // both plus inputs compare against the shared reference on bit 3
    assign cmp1_raw = vin1 > vref;
    assign cmp2_raw = vin2 > vref;
    initial begin
        port3_in = 4'hF;
        load_external_data_op = 1'b0;
        load_program_const_op = 1'b0;
        mem_addr = 16'hFFFF;
    end
    task pin(input int i, input logic v);
        @(posedge clk);
        port3_in[i] <= v;
    endtask
    task volts(input int a, input int b, input int r);
        @(posedge clk);
        vin1 <= a;
        vin2 <= b;
        vref <= r;
    endtask
    // one load held until mem_end; ext picks data space over program space
    task mem_go(input logic ext, input logic [15:0] a);
        @(posedge clk);
        load_external_data_op <= ext;
        load_program_const_op <= !ext;
        mem_addr <= a;
    endtask
    task mem_end();
        @(posedge clk);
        load_external_data_op <= 1'b0;
        load_program_const_op <= 1'b0;
        mem_addr <= ~mem_addr; // released bus shows no stale address
    endtask
endmodule // p3s_pins_model
`default_nettype wire

// *** tb/tb_p3s_top.sv ***
// Purpose: register-level self-checking bench for the port 3 block
// Assumes: ce held high; romless strap changes only while in reset
// Notes: pins and memory strobes come from p3s_pins_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_p3s_top;
    // *****************************************************************
    // signals, dut and partner
    // *****************************************************************
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic timer1_out = 1'b0, hs0_out = 1'b0, hs1_out = 1'b0, romless_strap = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, lerr, timer1_in, hs0_in, data_space_ok, irq, analog_en;
    logic keeper_en, clk_limit_4mhz, cmp1_raw, cmp2_raw, hs1_in;
    logic load_external_data_op, load_program_const_op;
    logic [3:0] port3_in, port3_out, irq_req;
    logic [15:0] mem_addr;
    logic [4:0] low_emi;
    logic [1:0] open_drain;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    p3s_top i_dut (.clk, .rst_b, .ce(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .port3_in, .cmp1_raw, .cmp2_raw, .port3_out,
        .timer1_out, .timer1_in, .hs0_out, .hs1_out, .hs0_in, .hs1_in,
        .load_external_data_op, .load_program_const_op, .mem_addr, .romless_strap,
        .data_space_ok, .irq_req, .irq, .analog_en, .low_emi, .open_drain, .keeper_en,
        .clk_limit_4mhz);
    p3s_pins_model i_pins (.clk, .port3_in, .cmp1_raw, .cmp2_raw, .load_external_data_op,
        .load_program_const_op, .mem_addr);
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task final_report();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one bus transfer; read data and error flag land in q and lerr
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        `CHK(pready, 1'b1)
        q = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task settle();
        repeat (8) @(posedge clk);
    endtask
    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial begin
        repeat (5) @(posedge clk);
        `CHK(port3_out, 4'hF)
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(keeper_en, 1'b1)
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK({lerr, q}, 33'h0)
        end
        apb(1'b0, 8'h24, 32'h0);
        `CHK({lerr, q}, 33'h100000000)
        apb(1'b1, p3s_pkg::REG_PIN, 32'hF);
        `CHK(lerr, 1'b1)
        apb(1'b1, p3s_pkg::REG_PCFG, 32'hA5);
        apb(1'b0, p3s_pkg::REG_PCFG, 32'h0);
        `CHK(q, 32'hA5)
        `CHK({low_emi, open_drain}, 7'b1000101)
        apb(1'b1, p3s_pkg::REG_RCV, 32'h2);
        settle();
        `CHK(clk_limit_4mhz, 1'b1)
        apb(1'b1, p3s_pkg::REG_PCFG, 32'h0);
        settle();
        `CHK(clk_limit_4mhz, 1'b0)
        apb(1'b1, p3s_pkg::REG_DOUT, 32'h5);
        apb(1'b1, p3s_pkg::REG_MODE, 32'h80);
        for (int t = 0; t < 2; t++) begin
            timer1_out <= t[0];
            settle();
            `CHK(port3_out, {1'b0, t[0], 2'b01})
        end
        apb(1'b1, p3s_pkg::REG_MODE, 32'h100);
        hs0_out <= 1'b1;
        i_pins.pin(2, 1'b0);
        settle();
        `CHK({port3_out, hs0_in}, 5'b01110)
        i_pins.pin(1, 1'b0);
        settle();
        `CHK(timer1_in, 1'b0)
        // second handshake: select 1 uses bits 3 and 6, select 0 bits 1 and 4
        apb(1'b1, p3s_pkg::REG_MODE, 32'h600);
        settle();
        `CHK({port3_out, hs1_in}, 5'b00011)
        apb(1'b1, p3s_pkg::REG_MODE, 32'h200);
        settle();
        `CHK({port3_out, hs1_in}, 5'b01000)
        apb(1'b1, p3s_pkg::REG_MODE, 32'h40);
        i_pins.mem_go(1'b0, 16'h0800);
        settle();
        `CHK(port3_out, 4'h5)
        i_pins.mem_go(1'b1, 16'h0FFF);
        settle();
        `CHK({port3_out, data_space_ok}, 5'b01000)
        i_pins.mem_go(1'b1, p3s_pkg::EXT_DATA_BASE);
        settle();
        apb(1'b0, p3s_pkg::REG_DSP, 32'h0);
        `CHK(q, 32'h1)
        i_pins.mem_end();
        apb(1'b1, p3s_pkg::REG_MODE, 32'h0);
        apb(1'b0, p3s_pkg::REG_IST, 32'h0);
        apb(1'b1, p3s_pkg::REG_IMSK, 32'h8);
        i_pins.pin(0, 1'b0);
        settle();
        `CHK(irq, 1'b1)
        apb(1'b0, p3s_pkg::REG_IST, 32'h0);
        `CHK(q, 32'h8)
        i_pins.pin(3, 1'b0);
        settle();
        `CHK(irq, 1'b0)
        i_pins.pin(0, 1'b1);
        i_pins.pin(3, 1'b1);
        settle();
        apb(1'b0, p3s_pkg::REG_IST, 32'h0);
        `CHK(q, 32'h2)
        // edge selection of bits 1 and 2: fall, rise, both
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, p3s_pkg::REG_MODE, 32'(m * 20));
            apb(1'b0, p3s_pkg::REG_IST, 32'h0);
            i_pins.pin(1, 1'b1);
            i_pins.pin(2, 1'b1);
            settle();
            apb(1'b0, p3s_pkg::REG_IST, 32'h0);
            `CHK(q, (m != 0) ? 32'h5 : 32'h0)
            i_pins.pin(1, 1'b0);
            i_pins.pin(2, 1'b0);
            settle();
            apb(1'b0, p3s_pkg::REG_IST, 32'h0);
            `CHK(q, (m != 1) ? 32'h5 : 32'h0)
        end
        // analog mode with both edges, comparators routed to bits 4 and 7
        i_pins.volts(200, 100, 150);
        apb(1'b1, p3s_pkg::REG_MODE, 32'h2A);
        apb(1'b1, p3s_pkg::REG_PCFG, 32'h1);
        settle();
        apb(1'b0, p3s_pkg::REG_IST, 32'h0);
        `CHK({analog_en, port3_out[3], port3_out[0]}, 3'b101)
        apb(1'b0, p3s_pkg::REG_PIN, 32'h0);
        `CHK(q, 32'h19)
        i_pins.volts(100, 200, 150);
        settle();
        `CHK({port3_out[3], port3_out[0]}, 2'b10)
        apb(1'b0, p3s_pkg::REG_IST, 32'h0);
        `CHK(q, 32'h5)
        // second reset in mid-run with the romless strap set
        romless_strap <= 1'b1;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({port3_out, keeper_en, irq}, 6'b111100)
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        apb(1'b0, p3s_pkg::REG_DSP, 32'h0);
        `CHK(q, 32'h2)
        final_report();
    end
endmodule // tb_p3s_top
`default_nettype wire
